// file: cgh_dev_model.sv
// Behavioural clock circuit that answers the host's control bits
`timescale 1ns/1ps
`default_nettype none
module cgh_dev_model
    import cgh_pkg::*;
(
    input wire logic i_clock, // System clock
    input wire logic i_rst_b, // Async reset, active low
    input wire cgh_ctrl_type i_ctrl, // Control bits from the host
    input wire logic i_main_fail, // Main clock lost from outside
    output var cgh_stat_type o_stat, // Flags back to the host
    output logic [3:0] o_run // Running: main, sub, on-chip, PLL
);
    logic stop_q;
    logic det_q;
    logic fire;
    // Detection fires once on an outside loss while enabled
    assign fire = i_main_fail & i_ctrl.osc_stop_detect_enable & ~det_q;
    // Stop mode holds until reset
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            stop_q <= 1'b0;
        end else if (i_ctrl.stop_mode_req) begin
            stop_q <= 1'b1;
        end
    end
    // Detection flag, dropped by the host's clear pulse
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            det_q <= 1'b0;
        end else if (fire) begin
            det_q <= 1'b1;
        end else if (i_ctrl.flag_clear) begin
            det_q <= 1'b0;
        end
    end
    // Flags, on-chip readback and shared interrupt
    assign o_stat = {det_q, det_q | i_main_fail | i_ctrl.main_clk_stop_bit,
                     det_q | i_ctrl.onchip_osc_select_bit, det_q};
    // Oscillators running; stop mode halts all but a watchdog on-chip clock
    assign o_run[3] = ~i_ctrl.main_clk_stop_bit & ~i_main_fail & ~stop_q;
    assign o_run[2] = i_ctrl.sub_osc_enable_bit & ~i_ctrl.sub_in_pin_direction
                      & ~i_ctrl.sub_pins_pullup_bit & ~stop_q;
    assign o_run[1] = ((i_ctrl.onchip_osc_select_bit | det_q) & ~stop_q)
                      | i_ctrl.watchdog_clk_select_bit;
    assign o_run[0] = i_ctrl.pll_on_bit & ~stop_q;
endmodule : cgh_dev_model
`default_nettype wire

// file: cgh_host.sv
// Clock generation host: APB command slave sequencing the clock control bits
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module cgh_host
    import cgh_pkg::*;
#(
    parameter int unsigned SUB_CYC = SUB_STAB_CYC,
    parameter int unsigned PLL_CYC = PLL_STAB_CYC
) (
    input wire logic i_clock, // 100 MHz system clock
    input wire logic i_rst_b, // Async reset, active low
    input wire logic i_psel, // APB select
    input wire logic i_penable, // APB enable
    input wire logic i_pwrite, // APB write
    input wire logic [7:0] i_paddr, // APB byte address
    input wire logic [31:0] i_pwdata, // APB write data
    output logic [31:0] o_prdata, // APB read data
    output logic o_pready, // APB ready
    output logic o_pslverr, // APB error on unmapped address
    input wire cgh_stat_type i_stat, // Flags from the clock circuit
    output var cgh_ctrl_type o_ctrl // Control bits to the clock circuit
);
    logic pready_q, pslverr_q;
    logic [31:0] prdata_q, rd_data;
    logic access, wr, ctrl_wr, cmd_wr, stat_wr, mapped;
    logic [31:0] ctrl_q;
    cgh_state_type state_q;
    cgh_op_type goal_q, cmd_op;
    logic refuse, cmd_ok;
    logic sub_en_q, sub_odir_q, sub_idir_q, pullup_q, sub_sel_q, oco_q;
    logic mstop_q, pll_on_q, pll_sel_q, det_en_q, psw_q, wait_q, stop_q;
    logic flag_clr_q, oco_dev_q, evt_src_q;
    logic sub_ready, pll_ready, err_flag, evt_flag, busy;
    logic sub_start, pll_start, pll_abort, sub_abort;

    // APB decode
    assign access = i_psel && i_penable && pready_q;
    assign wr = access && i_pwrite;
    assign ctrl_wr = wr && (i_paddr == CTRL_OFS);
    assign cmd_wr = wr && (i_paddr == CMD_OFS);
    assign stat_wr = wr && (i_paddr == STAT_OFS);
    assign busy = (state_q != ST_IDLE);

    // Read mux and address check
    always_comb begin
        rd_data = 32'h0000_0000;
        mapped = 1'b1;
        if (i_paddr == CTRL_OFS) begin
            rd_data = ctrl_q;
        end else if (i_paddr == CMD_OFS) begin
            rd_data = {28'h0000000, goal_q};
        end else if (i_paddr == STAT_OFS) begin
            rd_data = {24'h000000, oco_q, i_stat.main_clk_stopped_flag,
                i_stat.stop_detected_flag, evt_flag, pll_ready, sub_ready,
                err_flag, busy};
        end else begin
            mapped = 1'b0;
        end
    end

    // APB response: one wait state, data and error registered with ready
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pready_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= i_psel && i_penable && !pready_q;
            prdata_q <= rd_data;
            pslverr_q <= i_psel && i_penable && !pready_q && !mapped;
        end
    end

    // Control register: divider, watchdog select, external clock, stop-in-wait, freq
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctrl_q <= CTRL_RST;
        end else if (ctrl_wr) begin
            ctrl_q <= i_pwdata;
        end
    end

    // Command check against current state
    assign cmd_op = cgh_op_type'(i_pwdata[3:0]);
    always_comb begin
        refuse = 1'b0;
        if (busy || i_pwdata[3:0] > CMD_MAX) begin
            refuse = 1'b1;
        end else begin
            case (cmd_op)
                OP_NONE: refuse = 1'b1;
                OP_SEL_SUB: refuse = !sub_ready;
                OP_SEL_PLL: refuse = !pll_ready;
                OP_SEL_MAIN: refuse = mstop_q;
                OP_STOP_MAIN: refuse = ctrl_q[EXT_BIT] || !(sub_sel_q || oco_q);
                OP_DET_ON: refuse = ctrl_q[FREQ_LSB +: 16] <= MIN_DETECT_KHZ;
                default: refuse = 1'b0;
            endcase
        end
    end
    assign cmd_ok = cmd_wr && !refuse;

    // Timer controls
    assign sub_start = (state_q == ST_SUB_EN);
    assign pll_start = cmd_ok && (cmd_op == OP_PLL_ON);
    assign pll_abort = (state_q == ST_PLL_OFF);
    assign sub_abort = (state_q == ST_MODE) && (goal_q == OP_STOP);

    // Sequencer and device control bits
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q <= ST_IDLE;
            goal_q <= OP_NONE;
            sub_en_q <= 1'b0;
            sub_odir_q <= 1'b0;
            sub_idir_q <= 1'b0;
            pullup_q <= 1'b0;
            sub_sel_q <= 1'b0;
            oco_q <= 1'b0;
            mstop_q <= 1'b0;
            pll_on_q <= 1'b0;
            pll_sel_q <= 1'b0;
            det_en_q <= 1'b0;
            wait_q <= 1'b0;
            stop_q <= 1'b0;
            oco_dev_q <= 1'b0;
        end else begin
            wait_q <= 1'b0;
            stop_q <= 1'b0;
            oco_dev_q <= i_stat.onchip_osc_select_bit;
            case (state_q)
                ST_IDLE: begin
                    if (cmd_ok) begin
                        goal_q <= cmd_op;
                        case (cmd_op)
                            OP_SUB_ON: state_q <= ST_SUB_PINS;
                            OP_SEL_SUB: begin
                                sub_sel_q <= 1'b1;
                                oco_q <= 1'b0;
                                pll_sel_q <= 1'b0;
                            end
                            OP_SEL_OCO: begin
                                oco_q <= 1'b1;
                                sub_sel_q <= 1'b0;
                                pll_sel_q <= 1'b0;
                            end
                            OP_SEL_MAIN: begin
                                oco_q <= 1'b0;
                                sub_sel_q <= 1'b0;
                                pll_sel_q <= 1'b0;
                            end
                            OP_SEL_PLL: begin
                                pll_sel_q <= 1'b1;
                                oco_q <= 1'b0;
                                sub_sel_q <= 1'b0;
                            end
                            OP_MAIN_ON: mstop_q <= 1'b0;
                            OP_STOP_MAIN: state_q <= ST_DET_OFF;
                            OP_PLL_ON: begin
                                pll_on_q <= 1'b1;
                                state_q <= ST_PLL_WAIT;
                            end
                            OP_DET_ON: det_en_q <= 1'b1;
                            OP_DET_OFF: det_en_q <= 1'b0;
                            OP_WAIT, OP_STOP: state_q <= ST_PLL_DESEL;
                            default: state_q <= ST_IDLE;
                        endcase
                    end
                end
                ST_SUB_PINS: begin
                    sub_odir_q <= 1'b0;
                    sub_idir_q <= 1'b0;
                    pullup_q <= 1'b0;
                    state_q <= ST_SUB_EN;
                end
                ST_SUB_EN: begin
                    sub_en_q <= 1'b1;
                    state_q <= ST_SUB_WAIT;
                end
                ST_SUB_WAIT: begin
                    if (sub_ready) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_PLL_WAIT: begin
                    if (pll_ready) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_PLL_DESEL: begin
                    pll_sel_q <= 1'b0;
                    state_q <= ST_PLL_OFF;
                end
                ST_PLL_OFF: begin
                    pll_on_q <= 1'b0;
                    state_q <= (goal_q == OP_STOP) ? ST_DET_OFF : ST_MODE;
                end
                ST_DET_OFF: begin
                    det_en_q <= 1'b0;
                    state_q <= (goal_q == OP_STOP_MAIN) ? ST_MAIN_STOP : ST_MODE;
                end
                ST_MAIN_STOP: begin
                    mstop_q <= 1'b1;
                    state_q <= ST_IDLE;
                end
                ST_MODE: begin
                    wait_q <= (goal_q == OP_WAIT);
                    stop_q <= (goal_q == OP_STOP);
                    if (goal_q == OP_STOP) begin
                        sub_en_q <= 1'b0;
                    end
                    state_q <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
            // Follow the on-chip select that the circuit sets on a detected stop
            if (i_stat.onchip_osc_select_bit && !oco_dev_q) begin
                oco_q <= 1'b1;
            end
        end
    end

    // Peripheral stop in wait is held off while detection is in use
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            psw_q <= 1'b0;
        end else begin
            psw_q <= ctrl_q[PSW_BIT] && !det_en_q;
        end
    end

    // Clear pulse for the circuit's stop flags on a status write
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            flag_clr_q <= 1'b0;
        end else begin
            flag_clr_q <= stat_wr && i_pwdata[ST_EVT_BIT];
        end
    end

    // Last level of the stop indication, so that one stop sets the event only once
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            evt_src_q <= 1'b0;
        end else begin
            evt_src_q <= i_stat.osc_irq && i_stat.stop_detected_flag;
        end
    end

    // Stabilisation timers
    cgh_wait_timer #(.CYCLES(SUB_CYC)) u_sub_tmr (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_start(sub_start),
        .i_abort(sub_abort),
        .o_done(sub_ready)
    );
    cgh_wait_timer #(.CYCLES(PLL_CYC)) u_pll_tmr (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_start(pll_start),
        .i_abort(pll_abort),
        .o_done(pll_ready)
    );

    // Refused command flag, cleared by writing status bit 1
    cgh_sticky u_err (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_set(cmd_wr && refuse),
        .i_clr(stat_wr && i_pwdata[1]),
        .o_flag(err_flag)
    );
    // Oscillation stop identified on the shared interrupt
    cgh_sticky u_evt (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_set(i_stat.osc_irq && i_stat.stop_detected_flag && !evt_src_q),
        .i_clr(stat_wr && i_pwdata[ST_EVT_BIT]),
        .o_flag(evt_flag)
    );

    // Output wiring, all from flops
    assign o_prdata = prdata_q;
    assign o_pready = pready_q;
    assign o_pslverr = pslverr_q;
    assign o_ctrl.main_clk_stop_bit = mstop_q;
    assign o_ctrl.sub_osc_enable_bit = sub_en_q;
    assign o_ctrl.sub_clk_select_bit = sub_sel_q;
    assign o_ctrl.onchip_osc_select_bit = oco_q;
    assign o_ctrl.osc_stop_detect_enable = det_en_q;
    assign o_ctrl.periph_stop_in_wait_bit = psw_q;
    assign o_ctrl.pll_select_bit = pll_sel_q;
    assign o_ctrl.pll_on_bit = pll_on_q;
    assign o_ctrl.pll_div3_bit = ctrl_q[PLL_DIV_BIT];
    assign o_ctrl.watchdog_clk_select_bit = ctrl_q[WDT_BIT];
    assign o_ctrl.sub_out_pin_direction = sub_odir_q;
    assign o_ctrl.sub_in_pin_direction = sub_idir_q;
    assign o_ctrl.sub_pins_pullup_bit = pullup_q;
    assign o_ctrl.cpu_clk_divider_field = ctrl_q[DIV_LSB +: 5];
    assign o_ctrl.flag_clear = flag_clr_q;
    assign o_ctrl.wait_mode_req = wait_q;
    assign o_ctrl.stop_mode_req = stop_q;

    // Checks
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);

    ext_clk_stop_a: assert property ($rose(mstop_q) |-> !ctrl_q[EXT_BIT])
        else $error("main stop set with external clock");
    sub_pins_in_a: assert property ($rose(sub_en_q) |-> !sub_odir_q && !sub_idir_q)
        else $error("sub enable with pins not inputs");
    sub_pullup_off_a: assert property ($rose(sub_en_q) |-> !pullup_q && !sub_idir_q)
        else $error("sub enable with pull-up on");
    sub_sel_ready_a: assert property ($rose(sub_sel_q) |-> sub_ready)
        else $error("sub selected before stable");
    irq_source_a: assert property ($rose(i_stat.osc_irq && i_stat.stop_detected_flag)
        |=> evt_flag)
        else $error("stop event not recorded");
    wait_psw_a: assert property (det_en_q && wait_q |-> !psw_q)
        else $error("wait with peripherals stopping under detection");
    det_off_stop_a: assert property (($rose(mstop_q) || stop_q) |-> !det_en_q)
        else $error("main stopped with detection on");
    det_freq_a: assert property ($rose(det_en_q)
        |-> $past(ctrl_q[FREQ_LSB +: 16]) > MIN_DETECT_KHZ)
        else $error("detection enabled at low main frequency");
    pll_sel_ready_a: assert property ($rose(pll_sel_q) |-> pll_ready && pll_on_q)
        else $error("pll selected before stable");
    pll_mode_order_a: assert property ((wait_q || stop_q)
        |-> !pll_sel_q && !pll_on_q && $past(!pll_on_q) && $past(!pll_sel_q, 2))
        else $error("mode entered with pll active");

    sub_switch_c: cover property ($rose(sub_sel_q) && sub_ready);
    pll_switch_c: cover property ($rose(pll_sel_q) && pll_on_q);
    stop_mode_c: cover property (stop_q);
    osc_event_c: cover property ($rose(evt_flag));
endmodule : cgh_host
`default_nettype wire

// file: cgh_pkg.sv
// Package for the clock generation host: map, commands, states, carriers
package cgh_pkg;
    // Clock rate and stabilisation times
    localparam int CLK_MHZ = 100;
    localparam int SUB_STAB_US = 2000;
    localparam int PLL_STAB_US = 20000;
    localparam int SUB_STAB_CYC = SUB_STAB_US * CLK_MHZ;
    localparam int PLL_STAB_CYC = PLL_STAB_US * CLK_MHZ;
    // Detection needs a main clock above this (kHz)
    localparam logic [15:0] MIN_DETECT_KHZ = 16'h07D0;
    // Register offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] CMD_OFS = 8'h04;
    localparam logic [7:0] STAT_OFS = 8'h08;
    // Control register fields and reset value (divider 5'h08 is divide by 8)
    localparam int DIV_LSB = 0;
    localparam int WDT_BIT = 8;
    localparam int EXT_BIT = 9;
    localparam int PSW_BIT = 10;
    localparam int PLL_DIV_BIT = 11;
    localparam int FREQ_LSB = 16;
    localparam logic [31:0] CTRL_RST = 32'h0000_0008;
    // Status bits
    localparam int ST_EVT_BIT = 4;
    // Commands written to the command register
    typedef enum logic [3:0] {
        OP_NONE, OP_SUB_ON, OP_SEL_SUB, OP_SEL_MAIN, OP_SEL_OCO, OP_STOP_MAIN,
        OP_MAIN_ON, OP_PLL_ON, OP_SEL_PLL, OP_DET_ON, OP_DET_OFF, OP_WAIT, OP_STOP
    } cgh_op_type;
    localparam logic [3:0] CMD_MAX = 4'hC;
    // Sequencer states
    typedef enum logic [3:0] {
        ST_IDLE, ST_SUB_PINS, ST_SUB_EN, ST_SUB_WAIT, ST_PLL_WAIT,
        ST_PLL_DESEL, ST_PLL_OFF, ST_DET_OFF, ST_MAIN_STOP, ST_MODE
    } cgh_state_type;
    // Control bits driven into the clock circuit
    typedef struct packed {
        logic main_clk_stop_bit;
        logic sub_osc_enable_bit;
        logic sub_clk_select_bit;
        logic onchip_osc_select_bit;
        logic osc_stop_detect_enable;
        logic periph_stop_in_wait_bit;
        logic pll_select_bit;
        logic pll_on_bit;
        logic pll_div3_bit;
        logic watchdog_clk_select_bit;
        logic sub_out_pin_direction;
        logic sub_in_pin_direction;
        logic sub_pins_pullup_bit;
        logic [4:0] cpu_clk_divider_field;
        logic flag_clear;
        logic wait_mode_req;
        logic stop_mode_req;
    } cgh_ctrl_type;
    // State reported back by the clock circuit
    typedef struct packed {
        logic stop_detected_flag;
        logic main_clk_stopped_flag;
        logic onchip_osc_select_bit;
        logic osc_irq;
    } cgh_stat_type;
endpackage : cgh_pkg

// file: cgh_sticky.sv
// Sticky flag where a set in the clear cycle wins
`timescale 1ns/1ps
`default_nettype none
module cgh_sticky (
    input wire logic i_clock, // System clock
    input wire logic i_rst_b, // Async reset, active low
    input wire logic i_set, // Event
    input wire logic i_clr, // Clear request
    output logic o_flag // Held flag
);
    // Set has priority over clear
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_flag <= 1'b0;
        end else if (i_set) begin
            o_flag <= 1'b1;
        end else if (i_clr) begin
            o_flag <= 1'b0;
        end
    end
endmodule : cgh_sticky
`default_nettype wire

// file: cgh_wait_timer.sv
// Stabilisation wait timer: done rises CYCLES edges after start
`timescale 1ns/1ps
`default_nettype none
module cgh_wait_timer #(
    parameter int unsigned CYCLES = 16
) (
    input wire logic i_clock, // System clock
    input wire logic i_rst_b, // Async reset, active low
    input wire logic i_start, // Restart the wait
    input wire logic i_abort, // Drop the wait and done
    output logic o_done // Wait elapsed, level
);
    localparam int W = $clog2(CYCLES + 1);
    logic [W-1:0] cnt_q;
    logic run_q;
    // Down counter with sticky done
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_q <= '0;
            run_q <= 1'b0;
            o_done <= 1'b0;
        end else if (i_start) begin
            cnt_q <= W'(CYCLES);
            run_q <= 1'b1;
            o_done <= 1'b0;
        end else if (i_abort) begin
            run_q <= 1'b0;
            o_done <= 1'b0;
        end else if (run_q) begin
            cnt_q <= cnt_q - W'(1);
            if (cnt_q == W'(1)) begin
                run_q <= 1'b0;
                o_done <= 1'b1;
            end
        end
    end
endmodule : cgh_wait_timer
`default_nettype wire

// file: clock_source_select_osc_monitor_tb.sv
// Self-checking bench for the clock generation host
`timescale 1ns/1ps
`default_nettype none
module clock_source_select_osc_monitor_tb
    import cgh_pkg::*;
;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic main_fail = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    cgh_stat_type stat;
    cgh_ctrl_type ctrl;
    logic [3:0] run;
    logic [31:0] rd;
    logic serr;
    int n_mismatch = 0;
    int tests_run = 0;
    // Clock at 100 MHz
    always #5 clock = ~clock;
    cgh_host #(.SUB_CYC(8), .PLL_CYC(12)) dut (.i_clock(clock), .i_rst_b(rst_b),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_stat(stat), .o_ctrl(ctrl));
    cgh_dev_model model (.i_clock(clock), .i_rst_b(rst_b), .i_ctrl(ctrl),
        .i_main_fail(main_fail), .o_stat(stat), .o_run(run));
    // Verdict and end of run
    task finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test
    // Compare one value
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    // One APB transfer; returns at the completion edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk(32'(n < 20), 32'h1, "apb ready");
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task cmd(input logic [3:0] op);
        apb(1'b1, CMD_OFS, {28'h0, op});
    endtask : cmd
    // Let n edges pass and their updates settle
    task cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc
    // Poll a status bit with a bounded count
    task wait_stat(input int b);
        rd = 32'h0;
        for (int k = 0; k < 40 && rd[b] !== 1'b1; k++) apb(1'b0, STAT_OFS, 32'h0);
        chk(32'(rd[b]), 32'h1, "status ready");
    endtask : wait_stat
    task t_reset();
        cgh_ctrl_type e;
        logic [3:0] bad [5];
        e = '0;
        e.cpu_clk_divider_field = 5'h08;
        bad = '{4'h0, 4'hD, 4'hF, 4'h2, 4'h8};
        chk(32'(ctrl), 32'(e), "reset ctrl");
        chk(32'(run), 32'h8, "reset osc");
        apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
        chk(32'(serr), 32'h1, "unmapped write");
        apb(1'b0, 8'h0C, 32'h0);
        chk({rd[30:0], serr}, 32'h1, "unmapped read");
        apb(1'b0, CTRL_OFS, 32'h0);
        chk(rd, CTRL_RST, "ctrl reg");
        foreach (bad[i]) begin
            cmd(bad[i]);
            apb(1'b0, STAT_OFS, 32'h0);
            chk(32'(rd[1]), 32'h1, "refused");
            apb(1'b1, STAT_OFS, 32'h2);
        end
        apb(1'b0, STAT_OFS, 32'h0);
        chk(32'(rd[1]), 32'h0, "error cleared");
    endtask : t_reset
    task t_div();
        logic [4:0] v [4];
        v = '{5'h00, 5'h01, 5'h0F, 5'h1F};
        foreach (v[i]) begin
            apb(1'b1, CTRL_OFS, {27'h0, v[i]});
            cyc(1);
            chk(32'(ctrl.cpu_clk_divider_field), 32'(v[i]), "divider");
        end
        apb(1'b1, CTRL_OFS, 32'h908);
        cyc(1);
        chk({ctrl.watchdog_clk_select_bit, run[1], ctrl.pll_div3_bit}, 32'h7,
            "watchdog and pll divider");
        apb(1'b1, CTRL_OFS, 32'h8);
    endtask : t_div
    task t_sub();
        cmd(OP_SUB_ON);
        cyc(1);
        chk({ctrl.sub_out_pin_direction, ctrl.sub_in_pin_direction,
             ctrl.sub_pins_pullup_bit, ctrl.sub_osc_enable_bit}, 32'h0, "sub pins");
        cyc(1);
        chk({ctrl.sub_osc_enable_bit, run[2]}, 32'h3, "sub enable");
        wait_stat(2);
        cmd(OP_SEL_SUB);
        cyc(0);
        chk({ctrl.sub_clk_select_bit, ctrl.onchip_osc_select_bit, ctrl.pll_select_bit},
            32'h4, "sub select");
    endtask : t_sub
    task t_stop_main();
        apb(1'b1, CTRL_OFS, 32'h208);
        cmd(OP_STOP_MAIN);
        cyc(0);
        chk(32'(ctrl.main_clk_stop_bit), 32'h0, "external clock");
        apb(1'b1, CTRL_OFS, 32'h07D0_0008);
        cmd(OP_DET_ON);
        cyc(0);
        chk(32'(ctrl.osc_stop_detect_enable), 32'h0, "slow main");
        apb(1'b1, CTRL_OFS, 32'h07D1_0008);
        cmd(OP_DET_ON);
        cyc(0);
        chk(32'(ctrl.osc_stop_detect_enable), 32'h1, "detect on");
        cmd(OP_STOP_MAIN);
        cyc(1);
        chk({ctrl.osc_stop_detect_enable, ctrl.main_clk_stop_bit}, 32'h0, "stop 1");
        cyc(1);
        chk({ctrl.main_clk_stop_bit, run[3]}, 32'h2, "stop 2");
        cmd(OP_MAIN_ON);
        cmd(OP_SEL_MAIN);
        cyc(0);
        chk({ctrl.main_clk_stop_bit, ctrl.sub_clk_select_bit}, 32'h0, "main back");
        cmd(OP_SEL_OCO);
        cyc(0);
        chk({ctrl.sub_clk_select_bit, ctrl.onchip_osc_select_bit, ctrl.pll_select_bit, run[1]},
            32'h5, "oco select");
        apb(1'b0, CMD_OFS, 32'h0);
        chk(rd, 32'h4, "command readback");
        cmd(OP_SEL_MAIN);
        cmd(OP_STOP_MAIN);
        cyc(2);
        chk(32'(ctrl.main_clk_stop_bit), 32'h0, "stop on main");
    endtask : t_stop_main
    task t_detect();
        apb(1'b1, CTRL_OFS, 32'h07D1_0408);
        cmd(OP_DET_ON);
        cyc(2);
        chk(32'(ctrl.periph_stop_in_wait_bit), 32'h0, "wait forced");
        @(posedge clock);
        main_fail <= 1'b1;
        cyc(4);
        apb(1'b0, STAT_OFS, 32'h0);
        chk(32'(rd[7:4]), 32'hF, "stop event");
        main_fail <= 1'b0;
        apb(1'b1, STAT_OFS, 32'h10);
        cyc(0);
        chk(32'(ctrl.flag_clear), 32'h1, "flag clear");
        apb(1'b0, STAT_OFS, 32'h0);
        chk(32'(rd[5:4]), 32'h0, "event cleared");
        cmd(OP_DET_OFF);
        cyc(2);
        chk(32'(ctrl.periph_stop_in_wait_bit), 32'h1, "wait free");
        cmd(OP_SEL_MAIN);
        apb(1'b1, CTRL_OFS, 32'h07D1_0008);
    endtask : t_detect
    task t_pll();
        logic [4:0] exp_stop [4];
        exp_stop = '{5'b01101, 5'b00101, 5'b00001, 5'b00010};
        cmd(OP_PLL_ON);
        cyc(0);
        chk(32'(ctrl.pll_on_bit), 32'h1, "pll on");
        cmd(OP_SEL_PLL);
        cyc(0);
        chk(32'(ctrl.pll_select_bit), 32'h0, "pll not ready");
        wait_stat(3);
        cmd(OP_SEL_PLL);
        cyc(0);
        chk({ctrl.sub_clk_select_bit, ctrl.onchip_osc_select_bit, ctrl.pll_select_bit},
            32'h1, "pll select");
        cmd(OP_DET_ON);
        cmd(OP_WAIT);
        cyc(1);
        chk({ctrl.pll_select_bit, ctrl.pll_on_bit, ctrl.wait_mode_req}, 32'h2, "wait 1");
        cyc(1);
        chk({ctrl.pll_select_bit, ctrl.pll_on_bit, ctrl.wait_mode_req}, 32'h0, "wait 2");
        cyc(1);
        chk({ctrl.pll_select_bit, ctrl.pll_on_bit, ctrl.wait_mode_req}, 32'h1, "wait 3");
        cmd(OP_PLL_ON);
        wait_stat(3);
        cmd(OP_SEL_PLL);
        cmd(OP_DET_ON);
        cmd(OP_STOP);
        for (int i = 0; i < 4; i++) begin
            cyc(1);
            chk({ctrl.pll_select_bit, ctrl.pll_on_bit, ctrl.osc_stop_detect_enable,
                 ctrl.stop_mode_req, ctrl.sub_osc_enable_bit},
                32'(exp_stop[i]), "stop mode");
        end
        cyc(1);
        chk(32'(run), 32'h0, "all stopped");
    endtask : t_pll
    // Watchdog against a hang
    initial begin
        #200000;
        n_mismatch++;
        finish_test();
    end
    // Main sequence
    initial begin
        repeat (8) @(posedge clock);
        rst_b <= 1'b1;
        cyc(1);
        t_reset();
        t_div();
        t_sub();
        t_stop_main();
        t_detect();
        t_pll();
        finish_test();
    end
endmodule : clock_source_select_osc_monitor_tb
`default_nettype wire
